// ==== hw/ssy_port_cfg.svh ====
// Register map, field positions, mode codes and timing counts of the serial port
`ifndef SSY_PORT_CFG_SVH
`define SSY_PORT_CFG_SVH

// Register byte addresses
`define SSY_ADDR_BUF 8'h13
`define SSY_ADDR_CTRL 8'h14
`define SSY_ADDR_STATUS 8'h94
`define SSY_ADDR_IRQ_ST 8'h20
`define SSY_ADDR_IRQ_MASK 8'h21

// Control register fields
`define SSY_CTRL_EN 5
`define SSY_CTRL_POL 4
`define SSY_CTRL_MODE_HI 3
`define SSY_CTRL_MODE_LO 0

// Status register fields
`define SSY_STAT_PHASE 7
`define SSY_STAT_EDGE 6
`define SSY_STAT_DA 5
`define SSY_STAT_FULL 0

// Mode codes in the control register
`define SSY_MODE_MST_DIV4 4'h0
`define SSY_MODE_MST_DIV16 4'h1
`define SSY_MODE_MST_DIV64 4'h2
`define SSY_MODE_SLV_SEL 4'h3
`define SSY_MODE_SLV_NOSEL 4'h4

// System clock cycles per half period of the master serial clock
`define SSY_HALF_DIV4 6'h02
`define SSY_HALF_DIV16 6'h08
`define SSY_HALF_DIV64 6'h20

// Master half-step markers and bit counting
`define SSY_STEP_FIRST 5'h01
`define SSY_STEP_LAST_LEAD 5'h0f
`define SSY_STEP_LAST_TRAIL 5'h10
`define SSY_STEP_END 5'h11
`define SSY_BIT_LAST 4'h7
`define SSY_DIV_TICK 6'h01

// Interrupt status bits
`define SSY_IRQ_DONE 0
`define SSY_IRQ_COLL 1
`define SSY_IRQ_OVF 2

// Reset values
`define SSY_RST_CTRL 6'h00
`define SSY_RST_BYTE 8'h00
`define SSY_RST_IRQ 3'h0

`endif

// ==== hw/ssy_port_pkg.sv ====
// Types of the synchronous serial port
package ssy_port_pkg;

	typedef enum logic [0:0] {
		SSY_IDLE,
		SSY_RUN
	} ssy_state_type;

	typedef struct packed {
		logic [5:0] ctrl;
		logic phase;
		logic tx_edge;
		logic full;
		logic [7:0] rx_buf;
		logic [7:0] tx_sr;
		logic [7:0] rx_sr;
		ssy_state_type state;
		logic [4:0] step;
		logic [5:0] div;
		logic [3:0] cnt;
		logic [1:0] sck_sync;
		logic sck_prev;
		logic [1:0] sel_sync;
		logic [1:0] din_sync;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic [7:0] rd_data;
		logic irq;
		logic sck;
		logic sck_oe_n;
		logic dout;
		logic dout_oe_n;
	} ssy_regs_type;

endpackage

// ==== hw/ssy_port.sv ====
// Synchronous serial port in SPI mode with register port and interrupt
`timescale 1ns/1ns
`include "ssy_port_cfg.svh"

module ssy_port
	import ssy_port_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Interrupt
	output logic irq_out,
	// Serial clock pin
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_n_out,
	// Serial data pins and select
	input wire logic serial_in_line_in,
	output logic serial_out_line_out,
	output logic serial_out_oe_n_out,
	input wire logic sel_n_in
);

	ssy_regs_type r_ff;
	ssy_regs_type nxt_r;

	// Half period count of the master clock for a mode code
	function automatic logic [5:0] half_count(input logic [3:0] mode);
		case (mode)
			`SSY_MODE_MST_DIV16: half_count = `SSY_HALF_DIV16;
			`SSY_MODE_MST_DIV64: half_count = `SSY_HALF_DIV64;
			default: half_count = `SSY_HALF_DIV4;
		endcase
	endfunction

	// Next state of the whole port
	always_comb begin
		logic [3:0] mode;
		logic pol;
		logic en;
		logic is_master;
		logic is_slave;
		logic sel_ok;
		logic busy;
		logic [4:0] k;
		logic lead;
		logic trail;
		logic fin;
		logic sample_now;
		logic shift_now;
		logic done;
		logic coll;
		logic edge_seen;
		mode = r_ff.ctrl[`SSY_CTRL_MODE_HI:`SSY_CTRL_MODE_LO];
		pol = r_ff.ctrl[`SSY_CTRL_POL];
		en = r_ff.ctrl[`SSY_CTRL_EN];
		k = 5'h00;
		lead = 1'b0;
		trail = 1'b0;
		fin = 1'b0;
		sample_now = 1'b0;
		shift_now = 1'b0;
		done = 1'b0;
		coll = 1'b0;
		edge_seen = 1'b0;
		nxt_r = r_ff;

		// Pin synchronisers, first stage read only by the second
		nxt_r.sck_sync = {r_ff.sck_sync[0], sck_in};
		nxt_r.sel_sync = {r_ff.sel_sync[0], sel_n_in};
		nxt_r.din_sync = {r_ff.din_sync[0], serial_in_line_in};
		nxt_r.sck_prev = r_ff.sck_sync[1];

		// Mode decode
		is_master = en && (mode == `SSY_MODE_MST_DIV4 || mode == `SSY_MODE_MST_DIV16 ||
			mode == `SSY_MODE_MST_DIV64);
		is_slave = en && (mode == `SSY_MODE_SLV_SEL || mode == `SSY_MODE_SLV_NOSEL);
		sel_ok = (mode != `SSY_MODE_SLV_SEL) || !r_ff.sel_sync[1];
		busy = (r_ff.state == SSY_RUN) || (r_ff.cnt != 4'h0);

		// Master clock generation, half steps 1..16 toggle, step 17 closes the frame
		if (is_master && r_ff.state == SSY_RUN) begin
			if (r_ff.div == `SSY_DIV_TICK) begin
				nxt_r.div = half_count(mode);
				k = r_ff.step + 5'h01;
				nxt_r.step = k;
				lead = k[0] && (k <= `SSY_STEP_LAST_LEAD);
				trail = !k[0] && (k <= `SSY_STEP_LAST_TRAIL);
				fin = (k == `SSY_STEP_END);
				if (lead || trail) begin
					nxt_r.sck = !r_ff.sck;
				end
				// Output change edge from the edge bit alone
				if (r_ff.tx_edge) begin
					shift_now = lead && (k != `SSY_STEP_FIRST);
				end else begin
					shift_now = trail && (k != `SSY_STEP_LAST_TRAIL);
				end
				// Input sample point from the phase and edge bits
				if (r_ff.phase) begin
					sample_now = r_ff.tx_edge ? ((lead && k != `SSY_STEP_FIRST) || fin) : trail;
				end else begin
					sample_now = r_ff.tx_edge ? trail : lead;
				end
				done = fin;
			end else begin
				nxt_r.div = r_ff.div - `SSY_DIV_TICK;
			end
		end else if (is_slave) begin
			// Slave follows edges of the outside clock, sampling opposite to output change
			nxt_r.state = SSY_IDLE;
			if (sel_ok) begin
				edge_seen = r_ff.sck_sync[1] != r_ff.sck_prev;
				lead = edge_seen && (r_ff.sck_sync[1] != pol);
				trail = edge_seen && (r_ff.sck_sync[1] == pol);
				shift_now = (r_ff.cnt != 4'h0) && (r_ff.tx_edge ? lead : trail);
				sample_now = r_ff.tx_edge ? trail : lead;
				done = sample_now && (r_ff.cnt == `SSY_BIT_LAST);
			end else begin
				nxt_r.cnt = 4'h0;
			end
		end else begin
			// Port off or mode change: abort and rest the clock
			nxt_r.state = SSY_IDLE;
			nxt_r.cnt = 4'h0;
		end

		// Idle clock level
		if (nxt_r.state == SSY_IDLE && !(is_master && r_ff.state == SSY_RUN)) begin
			nxt_r.sck = pol;
		end

		// Shift out and shift in
		if (shift_now) begin
			nxt_r.tx_sr = {r_ff.tx_sr[6:0], 1'b0};
		end
		if (sample_now) begin
			nxt_r.rx_sr = {r_ff.rx_sr[6:0], r_ff.din_sync[1]};
			nxt_r.cnt = r_ff.cnt + 4'h1;
		end

		// Register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				`SSY_ADDR_CTRL: begin
					nxt_r.ctrl = reg_wdata_in[5:0];
				end
				`SSY_ADDR_STATUS: begin
					nxt_r.phase = reg_wdata_in[`SSY_STAT_PHASE];
					nxt_r.tx_edge = reg_wdata_in[`SSY_STAT_EDGE];
				end
				`SSY_ADDR_BUF: begin
					if (busy) begin
						coll = 1'b1;
					end else begin
						nxt_r.tx_sr = reg_wdata_in;
						if (is_master) begin
							nxt_r.state = SSY_RUN;
							nxt_r.step = 5'h00;
							nxt_r.div = half_count(mode);
						end
					end
				end
				`SSY_ADDR_IRQ_ST: begin
					nxt_r.irq_st = r_ff.irq_st & ~reg_wdata_in[2:0];
				end
				`SSY_ADDR_IRQ_MASK: begin
					nxt_r.irq_mask = reg_wdata_in[2:0];
				end
				default: begin
				end
			endcase
		end

		// Register reads, data valid in the next cycle only
		nxt_r.rd_data = `SSY_RST_BYTE;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`SSY_ADDR_CTRL: nxt_r.rd_data = {2'b00, r_ff.ctrl};
				`SSY_ADDR_STATUS: begin
					nxt_r.rd_data[`SSY_STAT_PHASE] = r_ff.phase;
					nxt_r.rd_data[`SSY_STAT_EDGE] = r_ff.tx_edge;
					nxt_r.rd_data[`SSY_STAT_DA] = 1'b0;
					nxt_r.rd_data[`SSY_STAT_FULL] = r_ff.full;
				end
				`SSY_ADDR_BUF: begin
					nxt_r.rd_data = r_ff.rx_buf;
					nxt_r.full = 1'b0;
				end
				`SSY_ADDR_IRQ_ST: nxt_r.rd_data = {5'h00, r_ff.irq_st};
				`SSY_ADDR_IRQ_MASK: nxt_r.rd_data = {5'h00, r_ff.irq_mask};
				default: nxt_r.rd_data = `SSY_RST_BYTE;
			endcase
		end

		// End of exchange; events set after clears so a set wins
		if (done) begin
			nxt_r.cnt = 4'h0;
			nxt_r.state = SSY_IDLE;
			nxt_r.irq_st[`SSY_IRQ_DONE] = 1'b1;
			if (r_ff.full) begin
				nxt_r.irq_st[`SSY_IRQ_OVF] = 1'b1; // Unread byte kept
			end else begin
				nxt_r.rx_buf = nxt_r.rx_sr;
			end
			nxt_r.full = 1'b1;
		end
		if (coll) begin
			nxt_r.irq_st[`SSY_IRQ_COLL] = 1'b1;
		end
		nxt_r.irq = |(nxt_r.irq_st & nxt_r.irq_mask);

		// Pin drivers, enables low while driving
		nxt_r.sck_oe_n = !is_master;
		nxt_r.dout = nxt_r.tx_sr[7];
		nxt_r.dout_oe_n = !(is_master || (is_slave && sel_ok));
	end

	// State register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r_ff.ctrl <= `SSY_RST_CTRL;
			r_ff.phase <= 1'b0;
			r_ff.tx_edge <= 1'b0;
			r_ff.full <= 1'b0;
			r_ff.rx_buf <= `SSY_RST_BYTE;
			r_ff.tx_sr <= `SSY_RST_BYTE;
			r_ff.rx_sr <= `SSY_RST_BYTE;
			r_ff.state <= SSY_IDLE;
			r_ff.step <= 5'h00;
			r_ff.div <= 6'h00;
			r_ff.cnt <= 4'h0;
			r_ff.sck_sync <= 2'b00;
			r_ff.sck_prev <= 1'b0;
			r_ff.sel_sync <= 2'b11;
			r_ff.din_sync <= 2'b00;
			r_ff.irq_st <= `SSY_RST_IRQ;
			r_ff.irq_mask <= `SSY_RST_IRQ;
			r_ff.rd_data <= `SSY_RST_BYTE;
			r_ff.irq <= 1'b0;
			r_ff.sck <= 1'b0;
			r_ff.sck_oe_n <= 1'b1;
			r_ff.dout <= 1'b0;
			r_ff.dout_oe_n <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_out = r_ff.rd_data;
	assign irq_out = r_ff.irq;
	assign sck_out = r_ff.sck;
	assign sck_oe_n_out = r_ff.sck_oe_n;
	assign serial_out_line_out = r_ff.dout;
	assign serial_out_oe_n_out = r_ff.dout_oe_n;

endmodule

// ==== verification/ssy_port_asserts.sv ====
// Checker of the register port and serial clock of the serial port
`timescale 1ns/1ns
`include "ssy_port_cfg.svh"
module ssy_port_asserts (
	// Clock, reset and register port
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic irq_out,
	// Serial pins
	input wire logic sck_in,
	input wire logic sck_out,
	input wire logic sck_oe_n_out,
	input wire logic serial_in_line_in,
	input wire logic serial_out_line_out,
	input wire logic serial_out_oe_n_out,
	input wire logic sel_n_in
);
	logic [5:0] ctrl_ff;
	logic [1:0] quiet_ff;
	logic [4:0] tog_ff;
	logic sck_d_ff;
	logic master;
	logic tog;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// Master mode and serial clock toggle seen this cycle
	assign master = ctrl_ff[5] && (ctrl_ff[3:0] <= 4'h2);
	assign tog = sck_out != sck_d_ff;
	// Control shadow, settle count, toggles since the last buffer write
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_ff <= 6'h00;
			quiet_ff <= 2'h3;
			tog_ff <= 5'h00;
			sck_d_ff <= 1'b0;
		end else begin
			sck_d_ff <= sck_out;
			quiet_ff <= (quiet_ff == 2'h3) ? 2'h3 : quiet_ff + 2'h1;
			if (reg_wr_in && reg_addr_in == `SSY_ADDR_CTRL) begin
				ctrl_ff <= reg_wdata_in[5:0];
				quiet_ff <= 2'h0;
			end
			if (reg_wr_in && reg_addr_in == `SSY_ADDR_BUF) begin
				tog_ff <= 5'h00;
			end else if (tog && tog_ff != 5'h1f) begin
				tog_ff <= tog_ff + 5'h01;
			end
		end
	end
	rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data not zero outside read cycle");
	unmapped_rd_a: assert property ($past(reg_rd_in) && !($past(reg_addr_in) inside
		{8'h13, 8'h14, 8'h94, 8'h20, 8'h21}) |-> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	ctrl_top_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == `SSY_ADDR_CTRL
		|-> reg_rdata_out[7:6] == 2'h0)
		else $error("control top bits not zero");
	stat_spare_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == `SSY_ADDR_STATUS
		|-> reg_rdata_out[5:1] == 5'h00)
		else $error("status spare bits not zero");
	clk_oe_a: assert property (quiet_ff == 2'h3 |-> sck_oe_n_out == !master)
		else $error("clock enable does not follow mode");
	sck_idle_a: assert property (quiet_ff == 2'h3 && (!master || tog_ff == 5'h10)
		|-> sck_out == ctrl_ff[4])
		else $error("serial clock not at idle level");
	frame_len_a: assert property (tog_ff <= 5'h10)
		else $error("more than sixteen clock toggles in a frame");
	half_period_a: assert property (quiet_ff == 2'h3 && master && ctrl_ff[3:0] == 4'h1
		&& tog && tog_ff < 5'h0f |=> !tog [*7] ##1 tog)
		else $error("half period not eight cycles");
	cover property (tog_ff == 5'h10);
	cover property ($rose(irq_out));
	cover property (!sck_oe_n_out && tog);
endmodule

bind ssy_port ssy_port_asserts u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
	.sck_in(sck_in), .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out),
	.serial_in_line_in(serial_in_line_in), .serial_out_line_out(serial_out_line_out),
	.serial_out_oe_n_out(serial_out_oe_n_out), .sel_n_in(sel_n_in));

// ==== verification/ssy_spi_peer.sv ====
// Model of the remote serial peer
`timescale 1ns/1ns
module ssy_spi_peer (
	// Serial clock and data lines
	input wire logic clk_in,
	input wire logic data_in,
	output logic data_out,
	// Byte to send and byte received
	input wire logic load_in,
	input wire logic [7:0] byte_in,
	output logic [7:0] byte_out
);
	logic [7:0] sh_ff;
	// MSB first, change on falling edges; spent bits come back inverted
	always @(posedge load_in or negedge clk_in) begin
		if (load_in) begin
			sh_ff <= byte_in;
		end else begin
			sh_ff <= {sh_ff[6:0], ~sh_ff[7]};
		end
	end
	// Sample on rising edges
	always @(posedge clk_in) begin
		byte_out <= {byte_out[6:0], data_in};
	end
	assign data_out = sh_ff[7];
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench of the serial port
`timescale 1ns/1ns
`include "ssy_port_cfg.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sck_in = 1'b0;
	logic sel_n = 1'b1;
	logic dout_oe_n;
	logic load = 1'b0;
	logic [7:0] ptx = 8'h00;
	logic [7:0] rdata, prx;
	logic irq, sck, sck_oe_n, miso, mosi;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int i;
	// Clock and instances
	always #50 clk = ~clk;
	ssy_port u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.irq_out(irq), .sck_in(sck_in), .sck_out(sck), .sck_oe_n_out(sck_oe_n),
		.serial_in_line_in(miso), .serial_out_line_out(mosi),
		.serial_out_oe_n_out(dout_oe_n), .sel_n_in(sel_n));
	ssy_spi_peer u_peer (.clk_in(sck_oe_n ? sck_in : sck), .data_in(mosi), .data_out(miso),
		.load_in(load), .byte_in(ptx), .byte_out(prx));
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check($sformatf("reg %h", a), rdata, exp);
	endtask
	task wait_irq;
		for (i = 0; i < 400 && irq !== 1'b1; i++) @(negedge clk);
		check("irq", {7'h00, irq}, 8'h01);
	endtask
	task close_out;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Cycle ceiling
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out;
		end
	end
	// Test sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(`SSY_ADDR_CTRL, 8'h00);
		rd_reg(`SSY_ADDR_STATUS, 8'h00);
		rd_reg(8'h55, 8'h00);
		wr_reg(`SSY_ADDR_STATUS, 8'hff);
		rd_reg(`SSY_ADDR_STATUS, 8'hc0);
		wr_reg(`SSY_ADDR_STATUS, 8'h00);
		wr_reg(`SSY_ADDR_CTRL, 8'hff);
		rd_reg(`SSY_ADDR_CTRL, 8'h3f);
		wr_reg(`SSY_ADDR_CTRL, 8'h31);
		repeat (3) @(negedge clk);
		check("sck idle", {7'h00, sck}, 8'h01);
		$display("test registers done");
		wr_reg(`SSY_ADDR_CTRL, 8'h21);
		wr_reg(`SSY_ADDR_IRQ_MASK, 8'h01);
		ptx <= 8'h3c;
		load <= 1'b1;
		wr_reg(`SSY_ADDR_BUF, 8'ha5);
		load <= 1'b0;
		wr_reg(`SSY_ADDR_BUF, 8'h00);
		rd_reg(`SSY_ADDR_IRQ_ST, 8'h02);
		wait_irq;
		rd_reg(`SSY_ADDR_STATUS, 8'h01);
		rd_reg(`SSY_ADDR_BUF, 8'h3c);
		rd_reg(`SSY_ADDR_STATUS, 8'h00);
		check("peer rx", prx, 8'ha5);
		wr_reg(`SSY_ADDR_IRQ_ST, 8'h07);
		rd_reg(`SSY_ADDR_IRQ_ST, 8'h00);
		check("irq", {7'h00, irq}, 8'h00);
		$display("test master done");
		@(posedge clk);
		sel_n <= 1'b0;
		wr_reg(`SSY_ADDR_CTRL, 8'h23);
		ptx <= 8'h96;
		load <= 1'b1;
		wr_reg(`SSY_ADDR_BUF, 8'h5a);
		load <= 1'b0;
		// Outside clock with an 800 ns period, changed at rising edges
		repeat (8) begin
			repeat (4) @(posedge clk);
			sck_in <= 1'b1;
			repeat (4) @(posedge clk);
			sck_in <= 1'b0;
		end
		wait_irq;
		rd_reg(`SSY_ADDR_BUF, 8'h96);
		check("peer rx", prx, 8'h5a);
		check("data oe", {7'h00, dout_oe_n}, 8'h00);
		@(posedge clk);
		sel_n <= 1'b1;
		repeat (4) @(negedge clk);
		check("data oe", {7'h00, dout_oe_n}, 8'h01);
		$display("test slave done");
		close_out;
	end
endmodule
